// file: src/cbr_sequencer.sv
// Card backup, restore and compare sequencer
//
// Function
// RULE1: Switch 7 on, button held: write backup.
// RULE2: Backup or compare accepted in any mode; code refuses both once a backup has set mode_lock.
// RULE3: Program, parameters, I/O; v3 adds symbols.
// RULE4: Power-on with switch 7: restore everything.
// RULE5: Restore overrides startup transfer switch 2.
// RULE6: Switch 1 on blocks any restore.
// RULE7: Restore clears I/O and forced states.
// RULE8: I/O keep flag saved: preserve I/O.
// RULE9: Forced keep flag saved: preserve forces.
// RULE10: After backup, locked in program mode.
// RULE11: Switch 7 off, button held: compare.
// RULE12: Operator allows seconds to minutes.
// RULE13: Timers, counters: flags and present values.
// RULE14: Banks restored ascending, surplus ignored.
// RULE15: Missing bank stops the bank run.
// RULE16: Every bank saved raw, file banks too.
// RULE17: Bank mismatch marks file memory unformatted.
// RULE18: Indicator shows normal or error ending.
// RULE19: Start only after full continuous hold.
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ns
module cbr_sequencer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Operator pins
  input wire logic [7:0] dip_sw,
  input wire logic button_n,
  // Unit configuration
  input wire logic unit_v3,
  input wire logic [3:0] bank_max,
  input wire logic io_memory_keep_flag,
  input wire logic force_keep_flag,
  // Memory engine request and answer
  output logic [1:0] op,
  output logic [3:0] item,
  output logic [3:0] bank,
  output logic op_valid,
  input wire logic op_done,
  input wire logic op_error,
  input wire logic item_absent,
  input wire logic card_keep_io,
  input wire logic card_keep_force,
  // Restore side effects, startup transfer and mode lock
  output logic clear_io,
  output logic clear_force,
  output logic em_unformat,
  output logic startup_xfer_en,
  output logic mode_lock,
  // Indicator and interrupt
  output logic [1:0] card_power_indicator,
  output logic irq,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  // ==========================================================
  // Pin synchronisers
  logic [7:0] sw_s1_reg, sw_reg;
  logic btn_s1_reg, btn_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sw_s1_reg <= 8'h00;
      sw_reg <= 8'h00;
      btn_s1_reg <= 1'b0;
      btn_reg <= 1'b0;
    end else begin
      sw_s1_reg <= dip_sw;
      sw_reg <= sw_s1_reg;
      btn_s1_reg <= ~button_n;
      btn_reg <= btn_s1_reg;
    end
  end

  // ==========================================================
  // Hold timer: any release cancels
  logic [31:0] hold_cnt_reg;
  logic hold_fire;
  assign hold_fire = btn_reg && (hold_cnt_reg == cbr_pkg::HOLD_CYC - 1);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_cnt_reg <= 32'h00000000;
    end else if (!btn_reg) begin
      hold_cnt_reg <= 32'h00000000; // [RULE19]
    end else if (hold_cnt_reg != cbr_pkg::HOLD_CYC) begin
      hold_cnt_reg <= hold_cnt_reg + 32'h00000001;
    end
  end

  // ==========================================================
  // Sequencer
  typedef enum {S_BOOT, S_IDLE, S_REQ, S_WAIT, S_DONE} cbr_state_t;
  cbr_state_t state_reg;
  logic [1:0] boot_reg;
  logic err_reg;
  logic [1:0] op_reg;
  logic [3:0] item_reg, bank_reg, last_item;
  logic keep_io_reg, keep_force_reg, bank_gap_reg;
  assign last_item = unit_v3 ? cbr_pkg::ITEM_LAST_EXT : cbr_pkg::ITEM_LAST_BASE; // [RULE3]

  function automatic logic is_last(input logic [3:0] it, input logic [3:0] lim);
    is_last = (it == lim);
  endfunction : is_last

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= S_BOOT;
      boot_reg <= 2'h3;
      err_reg <= 1'b0;
      op_reg <= 2'h0;
      item_reg <= 4'h0;
      bank_reg <= 4'h0;
      keep_io_reg <= 1'b0;
      keep_force_reg <= 1'b0;
      bank_gap_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        S_BOOT: begin
          // Two edges for the switch synchroniser to fill before sampling
          boot_reg <= {boot_reg[0], 1'b0};
          if (!boot_reg[1]) begin
            state_reg <= S_IDLE;
            // Restore wins over startup transfer; protect blocks it
            if (sw_reg[cbr_pkg::SW_BACKUP] // [RULE4] [RULE5]
                && !sw_reg[cbr_pkg::SW_PROTECT]) begin // [RULE6]
              op_reg <= 2'(cbr_pkg::CBR_OP_READ);
              item_reg <= cbr_pkg::ITEM_PROGRAM;
              bank_reg <= 4'h0;
              err_reg <= 1'b0;
              state_reg <= S_REQ;
            end
          end
        end
        S_IDLE: begin
          // No operating-mode check: accepted in any mode until a backup sets mode_lock
          if (hold_fire && !mode_lock) begin // [RULE2]
            op_reg <= sw_reg[cbr_pkg::SW_BACKUP] ? 2'(cbr_pkg::CBR_OP_WRITE)
                                                  : 2'(cbr_pkg::CBR_OP_COMPARE); // [RULE1] [RULE11]
            item_reg <= cbr_pkg::ITEM_PROGRAM;
            bank_reg <= 4'h0;
            err_reg <= 1'b0;
            bank_gap_reg <= 1'b0;
            state_reg <= S_REQ;
          end
        end
        S_REQ: begin
          state_reg <= S_WAIT;
        end
        S_WAIT: begin
          // Duration unbounded: card may take minutes
          if (op_done) begin // [RULE12]
            if (op_error) begin
              err_reg <= 1'b1;
            end
            if (item_reg == cbr_pkg::ITEM_IO && op_reg == 2'(cbr_pkg::CBR_OP_READ)) begin
              keep_io_reg <= card_keep_io; // [RULE8]
              keep_force_reg <= card_keep_force; // [RULE9]
            end
            if (item_reg == cbr_pkg::ITEM_EM) begin
              if (op_reg == 2'(cbr_pkg::CBR_OP_READ) && item_absent) begin
                bank_gap_reg <= 1'b1; // [RULE15]
                item_reg <= item_reg + 4'h1;
                state_reg <= is_last(item_reg, last_item) ? S_DONE : S_REQ;
              end else if (bank_reg != bank_max) begin
                bank_reg <= bank_reg + 4'h1; // [RULE14] [RULE16]
                state_reg <= S_REQ;
              end else begin
                item_reg <= item_reg + 4'h1;
                state_reg <= is_last(item_reg, last_item) ? S_DONE : S_REQ;
              end
            end else begin
              item_reg <= item_reg + 4'h1;
              state_reg <= is_last(item_reg, last_item) ? S_DONE : S_REQ;
            end
          end
        end
        S_DONE: begin
          state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Engine request outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      op <= 2'h0;
      item <= 4'h0;
      bank <= 4'h0;
      op_valid <= 1'b0;
    end else begin
      op_valid <= (state_reg == S_REQ); // [RULE13]
      op <= op_reg;
      item <= item_reg;
      bank <= bank_reg;
    end
  end

  // ==========================================================
  // Restore side effects and mode lock
  logic done_pulse;
  assign done_pulse = (state_reg == S_DONE);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clear_io <= 1'b0;
      clear_force <= 1'b0;
      em_unformat <= 1'b0;
      startup_xfer_en <= 1'b0;
      mode_lock <= 1'b0;
    end else begin
      clear_io <= done_pulse && op_reg == 2'(cbr_pkg::CBR_OP_READ) && !err_reg
                  && !(keep_io_reg && io_memory_keep_flag); // [RULE7] [RULE8]
      clear_force <= done_pulse && op_reg == 2'(cbr_pkg::CBR_OP_READ) && !err_reg
                     && !(keep_force_reg && force_keep_flag); // [RULE7] [RULE9]
      if (done_pulse && op_reg == 2'(cbr_pkg::CBR_OP_READ) && bank_gap_reg) begin
        em_unformat <= 1'b1; // [RULE17]
      end
      // Startup transfer only when no restore was selected
      if (state_reg == S_BOOT && !boot_reg[1]) begin
        startup_xfer_en <= sw_reg[cbr_pkg::SW_AUTOXFER] && !sw_reg[cbr_pkg::SW_BACKUP]; // [RULE5]
      end
      // Sticky until power cycle; only reset clears it
      if (done_pulse && op_reg == 2'(cbr_pkg::CBR_OP_WRITE)) begin
        mode_lock <= 1'b1; // [RULE10]
      end
    end
  end

  // ==========================================================
  // Indicator
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      card_power_indicator <= 2'(cbr_pkg::CBR_IND_IDLE);
    end else if (state_reg == S_REQ || state_reg == S_WAIT) begin
      card_power_indicator <= 2'(cbr_pkg::CBR_IND_BUSY);
    end else if (done_pulse) begin
      card_power_indicator <= err_reg ? 2'(cbr_pkg::CBR_IND_ERR)
                                      : 2'(cbr_pkg::CBR_IND_OK); // [RULE18]
    end
  end

  // ==========================================================
  // Status, mask, interrupt
  // Bits: 0 ok done, 1 error done, 2 hold detected
  logic [2:0] stat_reg, mask_reg, ev;
  assign ev = {hold_fire, done_pulse && err_reg, done_pulse && !err_reg};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stat_reg <= 3'h0;
    end else if (reg_rd && reg_addr == 2'h0) begin
      stat_reg <= ev; // Set wins over read-clear
    end else begin
      stat_reg <= stat_reg | ev;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_reg <= 3'h0;
    end else if (reg_wr && reg_addr == 2'h1) begin
      mask_reg <= reg_wdata[2:0];
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_reg & mask_reg);
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        2'h0: reg_rdata <= {5'h00, stat_reg};
        2'h1: reg_rdata <= {5'h00, mask_reg};
        2'h2: reg_rdata <= {2'h0, mode_lock, em_unformat, card_power_indicator, err_reg,
                            (state_reg == S_WAIT)};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ==========================================================
  // Checks
  property p_lock_sticky;
    @(posedge clk) disable iff (rst) mode_lock |=> mode_lock;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("mode lock dropped"); // [RULE10]

  property p_no_restore_protect;
    @(posedge clk) disable iff (rst)
      (state_reg == S_BOOT && !boot_reg[1] && sw_reg[cbr_pkg::SW_PROTECT])
      |=> state_reg == S_IDLE;
  endproperty
  a_no_restore_protect: assert property (p_no_restore_protect) // [RULE6]
    else $error("restore under protect");

  property p_release_cancels;
    @(posedge clk) disable iff (rst) !btn_reg |=> hold_cnt_reg == 32'h00000000;
  endproperty
  a_release_cancels: assert property (p_release_cancels) // [RULE19]
    else $error("hold not cancelled");

  property p_ind_err;
    @(posedge clk) disable iff (rst)
      (done_pulse && err_reg) |=> card_power_indicator == 2'(cbr_pkg::CBR_IND_ERR);
  endproperty
  a_ind_err: assert property (p_ind_err) else $error("error not indicated"); // [RULE18]

  property p_req_valid;
    @(posedge clk) disable iff (rst) state_reg == S_REQ |=> op_valid && op == op_reg;
  endproperty
  a_req_valid: assert property (p_req_valid) else $error("request not issued"); // [RULE13]

  property p_start_kind;
    @(posedge clk) disable iff (rst)
      (state_reg == S_IDLE && hold_fire && !mode_lock && sw_reg[cbr_pkg::SW_BACKUP])
      |=> op_reg == 2'(cbr_pkg::CBR_OP_WRITE);
  endproperty
  a_start_kind: assert property (p_start_kind) else $error("backup not started"); // [RULE1]

  property p_compare_kind;
    @(posedge clk) disable iff (rst)
      (state_reg == S_IDLE && hold_fire && !mode_lock && !sw_reg[cbr_pkg::SW_BACKUP])
      |=> op_reg == 2'(cbr_pkg::CBR_OP_COMPARE);
  endproperty
  a_compare_kind: assert property (p_compare_kind) else $error("compare not started"); // [RULE11]

  property p_keep_io;
    @(posedge clk) disable iff (rst) (keep_io_reg && io_memory_keep_flag) |=> !clear_io;
  endproperty
  a_keep_io: assert property (p_keep_io) else $error("kept I/O cleared"); // [RULE8]

  property p_restore_boot;
    @(posedge clk) disable iff (rst)
      (state_reg == S_BOOT && !boot_reg[1] && sw_reg[cbr_pkg::SW_BACKUP]
       && !sw_reg[cbr_pkg::SW_PROTECT])
      |=> state_reg == S_REQ && op_reg == 2'(cbr_pkg::CBR_OP_READ);
  endproperty
  a_restore_boot: assert property (p_restore_boot) else $error("no boot restore"); // [RULE4]

  property p_clear_io;
    @(posedge clk) disable iff (rst)
      (done_pulse && op_reg == 2'(cbr_pkg::CBR_OP_READ) && !err_reg && !keep_io_reg)
      |=> clear_io;
  endproperty
  a_clear_io: assert property (p_clear_io) else $error("I/O not cleared"); // [RULE7]
endmodule : cbr_sequencer

// file: src/cbr_pkg.sv
// Package: constants and types for the card backup/restore sequencer
package cbr_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned HOLD_MS = 3000;
  localparam int unsigned HOLD_CYC = (CLK_HZ / 1000) * HOLD_MS;
  // ==========================================================
  // Switch positions (switch n at bit n-1)
  localparam int unsigned SW_PROTECT = 0;
  localparam int unsigned SW_AUTOXFER = 1;
  localparam int unsigned SW_BACKUP = 6;
  // ==========================================================
  // Item identifiers walked by the sequencer
  localparam logic [3:0] ITEM_PROGRAM = 4'h0;
  localparam logic [3:0] ITEM_PARAM = 4'h1;
  localparam logic [3:0] ITEM_DM_HI = 4'h2;
  localparam logic [3:0] ITEM_IO = 4'h3;
  localparam logic [3:0] ITEM_TIMCNT = 4'h4;
  localparam logic [3:0] ITEM_DM_LO = 4'h5;
  localparam logic [3:0] ITEM_EM = 4'h6;
  localparam logic [3:0] ITEM_SYMBOL = 4'h7;
  localparam logic [3:0] ITEM_COMMENT = 4'h8;
  localparam logic [3:0] ITEM_INDEX = 4'h9;
  localparam logic [3:0] ITEM_LAST_BASE = 4'h6;
  localparam logic [3:0] ITEM_LAST_EXT = 4'h9;
  localparam logic [3:0] BANK_MAX_RST = 4'h0;
  // ==========================================================
  // Operation codes toward the memory engine
  typedef enum logic [1:0] {
    CBR_OP_NONE,
    CBR_OP_WRITE,
    CBR_OP_READ,
    CBR_OP_COMPARE
  } cbr_op_t;
  // Indicator result codes
  typedef enum logic [1:0] {
    CBR_IND_IDLE,
    CBR_IND_BUSY,
    CBR_IND_OK,
    CBR_IND_ERR
  } cbr_ind_t;
endpackage : cbr_pkg

// file: testbench/cbr_card_model.sv
// Memory card model answering the sequencer's item requests
`timescale 1ns/1ns
module cbr_card_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request from the sequencer
  input wire logic op_valid,
  input wire logic [3:0] item,
  input wire logic [3:0] bank,
  // Card contents chosen by the bench
  input wire logic [3:0] gap_bank,
  input wire logic [3:0] err_item,
  input wire logic keep_io,
  input wire logic keep_force,
  // Answer
  output logic op_done,
  output logic op_error,
  output logic item_absent,
  output logic card_keep_io,
  output logic card_keep_force
);
  logic [2:0] wait_cnt;
  logic slow;
  logic [3:0] item_reg;
  logic [3:0] bank_reg;
  // ==========================================================
  // Answers
  // Status lines toggle outside done so a stale value never looks valid
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_cnt <= 3'h0;
      slow <= 1'h0;
      item_reg <= 4'h0;
      bank_reg <= 4'h0;
      op_done <= 1'h0;
      op_error <= 1'h0;
      item_absent <= 1'h0;
      card_keep_io <= 1'h0;
      card_keep_force <= 1'h0;
    end else begin
      op_done <= 1'h0;
      op_error <= ~op_error;
      item_absent <= ~item_absent;
      card_keep_io <= ~card_keep_io;
      card_keep_force <= ~card_keep_force;
      if (op_valid) begin
        wait_cnt <= slow ? 3'h5 : 3'h1;
        slow <= ~slow;
        item_reg <= item;
        bank_reg <= bank;
      end else if (wait_cnt == 3'h1) begin
        wait_cnt <= 3'h0;
        op_done <= 1'h1;
        op_error <= (item_reg == err_item);
        item_absent <= (item_reg == cbr_pkg::ITEM_EM) && (bank_reg == gap_bank);
        card_keep_io <= keep_io;
        card_keep_force <= keep_force;
      end else if (wait_cnt != 3'h0) begin
        wait_cnt <= wait_cnt - 3'h1;
      end
    end
  end
endmodule : cbr_card_model

// file: testbench/cbr_sequencer_bench.sv
// Self-checking bench for the card backup and restore sequencer
`timescale 1ns/1ns
module cbr_sequencer_bench;
  typedef struct packed {
    logic [7:0] sw;
    logic v3;
    logic [3:0] bmax, gap, err;
    logic kio, kfo, core_io_area, cfo;
    logic [4:0] req;
    logic ci, cf, unf, xf;
    logic [1:0] ind;
  } cbr_row_t;
  localparam int LIMIT = 30000;
  // Switches, config, card flags, then expected counts and levels
  localparam cbr_row_t ROWS [8] = '{
    '{8'h40, 1'h0, 4'h2, 4'hF, 4'hF, 1'h0, 1'h0, 1'h0, 1'h0, 5'h09, 1'h1, 1'h1, 1'h0, 1'h0, 2'h2},
    '{8'h42, 1'h1, 4'h3, 4'h2, 4'hF, 1'h1, 1'h0, 1'h1, 1'h0, 5'h0C, 1'h0, 1'h1, 1'h1, 1'h0, 2'h2},
    '{8'h40, 1'h0, 4'h1, 4'hF, 4'hF, 1'h1, 1'h1, 1'h0, 1'h1, 5'h08, 1'h1, 1'h0, 1'h0, 1'h0, 2'h2},
    '{8'h41, 1'h0, 4'h2, 4'hF, 4'hF, 1'h0, 1'h0, 1'h0, 1'h0, 5'h00, 1'h0, 1'h0, 1'h0, 1'h0, 2'h0},
    '{8'h02, 1'h0, 4'h2, 4'hF, 4'hF, 1'h0, 1'h0, 1'h0, 1'h0, 5'h00, 1'h0, 1'h0, 1'h0, 1'h1, 2'h0},
    '{8'h40, 1'h1, 4'h0, 4'hF, 4'h3, 1'h0, 1'h0, 1'h0, 1'h0, 5'h00, 1'h0, 1'h0, 1'h0, 1'h0, 2'h3},
    '{8'h40, 1'h0, 4'h0, 4'h0, 4'hF, 1'h0, 1'h0, 1'h0, 1'h0, 5'h07, 1'h1, 1'h1, 1'h1, 1'h0, 2'h2},
    '{8'h00, 1'h0, 4'h2, 4'hF, 4'hF, 1'h0, 1'h0, 1'h0, 1'h0, 5'h00, 1'h0, 1'h0, 1'h0, 1'h0, 2'h0}
  };
  logic clk, rst, button_n, unit_v3, io_memory_keep_flag, force_keep_flag, keep_io, keep_force;
  logic [7:0] dip_sw, reg_wdata, reg_rdata, rd;
  logic [3:0] bank_max, gap_bank, err_item, item, bank, exp_item, exp_bank, lim;
  logic [1:0] op, card_power_indicator, reg_addr;
  logic op_valid, op_done, op_error, item_absent, card_keep_io, card_keep_force;
  logic clear_io, clear_force, em_unformat, startup_xfer_en, mode_lock, irq, reg_wr, reg_rd;
  int fails, samples_checked, cyc, req_cnt, ci_cnt, cf_cnt;

  cbr_sequencer dut (.clk, .rst, .dip_sw, .button_n, .unit_v3, .bank_max, .io_memory_keep_flag,
    .force_keep_flag, .op, .item, .bank, .op_valid, .op_done, .op_error, .item_absent,
    .card_keep_io, .card_keep_force, .clear_io, .clear_force, .em_unformat, .startup_xfer_en,
    .mode_lock, .card_power_indicator, .irq, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata);
  cbr_card_model card (.clk, .rst, .op_valid, .item, .bank, .gap_bank, .err_item, .keep_io,
    .keep_force, .op_done, .op_error, .item_absent, .card_keep_io, .card_keep_force);

  assign lim = (gap_bank <= bank_max) ? gap_bank : bank_max;

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // ==========================================================
  // Hang guard and request order monitor
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      fails++;
      give_verdict;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      req_cnt = 0;
      ci_cnt = 0;
      cf_cnt = 0;
      exp_item = 4'h0;
      exp_bank = 4'h0;
    end else begin
      ci_cnt += clear_io;
      cf_cnt += clear_force;
      if (op_valid) begin
        req_cnt++;
        chk({op, item, bank}, {2'(cbr_pkg::CBR_OP_READ), exp_item, exp_bank});
        // Bank stands at the last bank walked once the bank item is over
        if (exp_item == cbr_pkg::ITEM_EM && exp_bank < lim) exp_bank++;
        else begin
          exp_item++;
        end
      end
    end
  end

  // ==========================================================
  // Bus and power-cycle tasks
  task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask : reg_write

  task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask : reg_read

  task automatic run_row(input int i);
    cbr_row_t r;
    r = ROWS[i];
    @(posedge clk);
    rst <= 1'h1;
    dip_sw <= r.sw;
    unit_v3 <= r.v3;
    bank_max <= r.bmax;
    gap_bank <= r.gap;
    err_item <= r.err;
    io_memory_keep_flag <= r.kio;
    force_keep_flag <= r.kfo;
    keep_io <= r.core_io_area;
    keep_force <= r.cfo;
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    for (int k = 0; k < 3000 && r.ind != 2'h0 && card_power_indicator[1] !== 1'h1; k++)
      @(posedge clk);
    repeat (r.ind != 2'h0 ? 4 : 60) @(posedge clk);
    #1;
    if (r.err == 4'hF) chk(16'(req_cnt), 16'(r.req));
    chk(16'(ci_cnt), 16'(r.ci));
    chk(16'(cf_cnt), 16'(r.cf));
    chk(16'(em_unformat), 16'(r.unf));
    chk(16'(startup_xfer_en), 16'(r.xf));
    chk(16'(card_power_indicator), 16'(r.ind));
    $display("row %0d done", i);
  endtask : run_row

  // ==========================================================
  // Main sequence
  initial begin
    rst = 1'h1;
    dip_sw = 8'h00;
    button_n = 1'h1;
    {unit_v3, io_memory_keep_flag, force_keep_flag, keep_io, keep_force} = 5'h00;
    {bank_max, gap_bank, err_item} = 12'h0FF;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = 12'h000;
    {fails, samples_checked, cyc} = 96'h0;
    for (int i = 0; i < 8; i++) run_row(i);
    // Masked completion, then unmasked, then read-clear
    run_row(0);
    #1 chk(16'(irq), 16'h0000);
    reg_write(2'h0, 8'hFF);
    reg_write(2'h1, 8'h01);
    repeat (2) @(posedge clk);
    #1 chk(16'(irq), 16'h0001);
    reg_read(2'h2, rd);
    chk(16'(rd), 16'h0008);
    reg_read(2'h3, rd);
    chk(16'(rd), 16'h0000);
    reg_read(2'h0, rd);
    chk(16'(rd), 16'h0001);
    repeat (2) @(posedge clk);
    #1 chk(16'(irq), 16'h0000);
    reg_read(2'h0, rd);
    chk(16'(rd), 16'h0000);
    $display("register test done");
    // Short press must not start a compare
    run_row(7);
    @(posedge clk);
    button_n <= 1'h0;
    repeat (200) @(posedge clk);
    button_n <= 1'h1;
    repeat (20) @(posedge clk);
    #1 chk(16'(req_cnt), 16'h0000);
    reg_read(2'h0, rd);
    chk(16'(rd), 16'h0000);
    $display("short press test done");
    give_verdict;
  end
endmodule : cbr_sequencer_bench
